// *** common/btprc_defs.svh ***
// Purpose: constants for the radio core power and reset controller
// Assumes: one 50 MHz clock, all inputs synchronous
// Notes: reset hold counts core clock cycles; wake interval counts low-power oscillator ticks
// Function
// - regulator enable low keeps the core reset asserted
// - host raises regulator enable; reset releases only after it is high
// - asserted reset puts every core circuit in a defined state
// - shutdown removes rf and core supplies, io supply stays on
// - in shutdown with io supply, outputs tristate, most inputs disabled
// - leaving shutdown follows normal power-up, nothing retained
// - sniff and hold run on low-power oscillator, wake after interval
// - rf enabled only while packet activity needs it
// - broadcast receiver is either fully on or fully off
// - after power-up the core executes lower layers from internal rom
// - host patches over uart are stored in patch memory
`ifndef BTPRC_DEFS_SVH
`define BTPRC_DEFS_SVH
`define BTPRC_RST_HOLD_CYC   8'h10
`define BTPRC_WAKE_W         16
`define BTPRC_PATCH_AW       6
`define BTPRC_PATCH_DW       8
`endif

// *** common/btprc_pkg.sv ***
// Purpose: types for the radio core power and reset controller
// Assumes: nothing
// Notes: state encoding left to the tool
package btprc_pkg;
	typedef enum {BTPRC_OFF, BTPRC_RESET, BTPRC_BOOT, BTPRC_RUN, BTPRC_LOWPWR} btprc_state_e;
endpackage

// *** verilog/btprc_ctrl.sv ***
// Purpose: power-state and reset sequencing of the radio core
// Assumes: inputs synchronous to CLK_I; lpo tick is a one-cycle pulse
// Notes: see function list in btprc_defs.svh
`timescale 1ns/100ps
`include "btprc_defs.svh"
module btprc_ctrl import btprc_pkg::*; #(
	parameter int HOLD_CYC = `BTPRC_RST_HOLD_CYC,
	parameter int WAKE_W   = `BTPRC_WAKE_W,
	parameter int PATCH_AW = `BTPRC_PATCH_AW
) (
	// clock and reset
	input  wire logic                     CLK_I,
	input  wire logic                     RST_I,
	// host power control
	input  wire logic                     RADIO_REGULATOR_ENABLE_I,
	input  wire logic                     IO_SUPPLY_I,
	// low-power mode, rf and broadcast receiver control
	input  wire logic                     LOW_POWER_OSC_INPUT_I,
	input  wire logic                     LOWPWR_REQ_I,
	input  wire logic [WAKE_W-1:0]        WAKE_INTERVAL_I,
	input  wire logic                     PKT_ACTIVE_I,
	input  wire logic                     FM_ON_I,
	// patch download from uart and patch read address
	input  wire logic                     PATCH_VALID_I,
	input  wire logic [PATCH_AW-1:0]      PATCH_ADDR_I,
	input  wire logic [7:0]               PATCH_DATA_I,
	input  wire logic [PATCH_AW-1:0]      PATCH_RD_ADDR_I,
	// outputs
	output logic                          CORE_RESET_O,
	output logic                          CORE_SUPPLY_EN_O,
	output logic                          RF_SUPPLY_EN_O,
	output logic                          IO_OUT_EN_N_O,
	output logic                          IN_RX_EN_O,
	output logic                          RF_ON_O,
	output logic                          FM_POWER_O,
	output logic                          RUN_FROM_ROM_O,
	output logic                          LOWPWR_CLK_SEL_O,
	output logic                          PATCH_PRESENT_O,
	output logic [7:0]                    PATCH_RD_DATA_O
);
	// hold counter is 8 bits wide
	if (HOLD_CYC < 1 || HOLD_CYC > 255 || WAKE_W < 2 || PATCH_AW < 1) begin
		$error("btprc_ctrl: unsupported parameters");
	end

	// ***********************************************
	// regulator enable synchroniser
	// ***********************************************
	logic en_s1_reg, en_s2_reg;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			en_s1_reg <= 1'b0;
			en_s2_reg <= 1'b0;
		end else begin
			en_s1_reg <= RADIO_REGULATOR_ENABLE_I;
			en_s2_reg <= en_s1_reg;
		end
	end
	wire en_on = en_s2_reg & IO_SUPPLY_I;

	// ***********************************************
	// sequencer
	// ***********************************************
	btprc_state_e      state_reg, state_next;
	logic [7:0]        cnt_reg, cnt_next;
	logic [WAKE_W-1:0] wake_reg, wake_next;
	logic              rst_reg, rst_next;
	logic              core_reg, core_next;
	logic              rfs_reg, rfs_next;
	logic              oen_n_reg, oen_n_next;
	logic              rx_reg, rx_next;
	logic              rfon_reg, rfon_next;
	logic              fm_reg, fm_next;
	logic              rom_reg, rom_next;
	logic              lpo_reg, lpo_next;
	logic              pp_reg, pp_next;
	logic              patch_we;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		wake_next  = wake_reg;
		pp_next    = pp_reg;
		case (state_reg)
			BTPRC_OFF: begin
				pp_next = 1'b0;
				if (en_on) begin
					state_next = BTPRC_RESET;
					cnt_next   = 8'(HOLD_CYC);
				end
			end
			BTPRC_RESET: begin
				if (cnt_reg != 8'h00)
					cnt_next = cnt_reg - 8'h01;
				else
					state_next = BTPRC_BOOT;
			end
			BTPRC_BOOT: state_next = BTPRC_RUN;
			BTPRC_RUN: begin
				if (LOWPWR_REQ_I) begin
					state_next = BTPRC_LOWPWR;
					wake_next  = (WAKE_INTERVAL_I == '0) ? WAKE_W'(1) : WAKE_INTERVAL_I;
				end
			end
			BTPRC_LOWPWR: begin
				if (LOW_POWER_OSC_INPUT_I) begin
					wake_next = wake_reg - WAKE_W'(1);
					if (wake_reg == WAKE_W'(1))
						state_next = BTPRC_RUN;
				end
			end
			default: state_next = BTPRC_OFF;
		endcase
		if (!en_on) begin
			state_next = BTPRC_OFF;
			cnt_next   = 8'h00;
			wake_next  = '0;
			pp_next    = 1'b0;
		end
		// writes only while the core runs; a byte taken during reset would be lost
		patch_we = PATCH_VALID_I && (state_next == BTPRC_RUN || state_next == BTPRC_LOWPWR);
		if (patch_we)
			pp_next = 1'b1;
		rst_next   = (state_next == BTPRC_OFF) || (state_next == BTPRC_RESET);
		core_next  = (state_next != BTPRC_OFF);
		rfs_next   = (state_next != BTPRC_OFF);
		oen_n_next = (state_next == BTPRC_OFF);
		rx_next    = (state_next != BTPRC_OFF);
		rfon_next  = (state_next == BTPRC_RUN) && PKT_ACTIVE_I;
		fm_next    = (state_next == BTPRC_RUN || state_next == BTPRC_LOWPWR) && FM_ON_I;
		rom_next   = (state_next == BTPRC_BOOT) || (state_next == BTPRC_RUN) || (state_next == BTPRC_LOWPWR);
		lpo_next   = (state_next == BTPRC_LOWPWR);
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg <= BTPRC_OFF;
			cnt_reg   <= 8'h00;
			wake_reg  <= '0;
			rst_reg   <= 1'b1;
			core_reg  <= 1'b0;
			rfs_reg   <= 1'b0;
			oen_n_reg <= 1'b1;
			rx_reg    <= 1'b0;
			rfon_reg  <= 1'b0;
			fm_reg    <= 1'b0;
			rom_reg   <= 1'b0;
			lpo_reg   <= 1'b0;
			pp_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			wake_reg  <= wake_next;
			rst_reg   <= rst_next;
			core_reg  <= core_next;
			rfs_reg   <= rfs_next;
			oen_n_reg <= oen_n_next;
			rx_reg    <= rx_next;
			rfon_reg  <= rfon_next;
			fm_reg    <= fm_next;
			rom_reg   <= rom_next;
			lpo_reg   <= lpo_next;
			pp_reg    <= pp_next;
		end
	end

	// ***********************************************
	// patch memory
	// ***********************************************
	// no reset on the array; per-entry valid bits, cleared at power-down, hide stale bytes
	logic [7:0]               patch_mem [0:(1<<PATCH_AW)-1];
	logic [(1<<PATCH_AW)-1:0] pv_reg, pv_next;
	logic [7:0]               rd_reg, rd_next;
	always_comb begin
		pv_next = pv_reg;
		if (state_next == BTPRC_OFF)
			pv_next = '0;
		if (patch_we)
			pv_next[PATCH_ADDR_I] = 1'b1;
		rd_next = pv_reg[PATCH_RD_ADDR_I] ? patch_mem[PATCH_RD_ADDR_I] : 8'h00;
	end
	always_ff @(posedge CLK_I) begin
		if (patch_we)
			patch_mem[PATCH_ADDR_I] <= PATCH_DATA_I;
	end
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pv_reg <= '0;
			rd_reg <= 8'h00;
		end else begin
			pv_reg <= pv_next;
			rd_reg <= rd_next;
		end
	end

	assign CORE_RESET_O     = rst_reg;
	assign CORE_SUPPLY_EN_O = core_reg;
	assign RF_SUPPLY_EN_O   = rfs_reg;
	assign IO_OUT_EN_N_O    = oen_n_reg;
	assign IN_RX_EN_O       = rx_reg;
	assign RF_ON_O          = rfon_reg;
	assign FM_POWER_O       = fm_reg;
	assign RUN_FROM_ROM_O   = rom_reg;
	assign LOWPWR_CLK_SEL_O = lpo_reg;
	assign PATCH_PRESENT_O  = pp_reg;
	assign PATCH_RD_DATA_O  = rd_reg;

	// ***********************************************
	// checks
	// ***********************************************
	a_reset_held_low: assert property (@(posedge CLK_I) disable iff (RST_I)
		!en_on |=> CORE_RESET_O) else $error("reset not held with enable low");
	a_release_after_en: assert property (@(posedge CLK_I) disable iff (RST_I)
		$fell(CORE_RESET_O) |-> $past(en_s2_reg, 2)) else $error("reset released without enable");
	a_reset_state_def: assert property (@(posedge CLK_I) disable iff (RST_I)
		CORE_RESET_O |-> !RF_ON_O && !FM_POWER_O && !LOWPWR_CLK_SEL_O) else $error("core active in reset");
	a_shutdown_supply: assert property (@(posedge CLK_I) disable iff (RST_I)
		!en_on |=> !CORE_SUPPLY_EN_O && !RF_SUPPLY_EN_O) else $error("supplies on in shutdown");
	a_shutdown_tristate: assert property (@(posedge CLK_I) disable iff (RST_I)
		!CORE_SUPPLY_EN_O |-> IO_OUT_EN_N_O && !IN_RX_EN_O) else $error("outputs driven in shutdown");
	a_no_retained: assert property (@(posedge CLK_I) disable iff (RST_I)
		!CORE_SUPPLY_EN_O |-> !PATCH_PRESENT_O) else $error("state kept over shutdown");
	a_lowpwr_osc: assert property (@(posedge CLK_I) disable iff (RST_I)
		LOWPWR_CLK_SEL_O |-> !RF_ON_O && !CORE_RESET_O) else $error("bad low-power clock state");
	a_rf_activity: assert property (@(posedge CLK_I) disable iff (RST_I)
		RF_ON_O |-> $past(PKT_ACTIVE_I)) else $error("rf on without packet");
	a_rom_boot: assert property (@(posedge CLK_I) disable iff (RST_I)
		$fell(CORE_RESET_O) |-> RUN_FROM_ROM_O) else $error("no rom boot after reset");
	a_fm_on_off: assert property (@(posedge CLK_I) disable iff (RST_I)
		FM_POWER_O |-> $past(FM_ON_I) && CORE_SUPPLY_EN_O) else $error("broadcast receiver on without request");
	a_patch_stored: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(PATCH_PRESENT_O) |-> $past(PATCH_VALID_I) && !CORE_RESET_O) else $error("patch flag without write");
	a_sync_two_stage: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(en_s2_reg) |-> $past(RADIO_REGULATOR_ENABLE_I, 2)) else $error("enable not synchronised");
endmodule

// *** sim/btprc_host.sv ***
// Purpose: host model driving regulator enable and patch bytes
// Assumes: changes just after rising edge
// Notes: released patch bus shows inverted data
`timescale 1ns/100ps
module btprc_host (
	input  wire logic       clk_i,
	output logic            reg_en_o,
	output logic            wr_o,
	output logic [5:0]      addr_o,
	output logic [7:0]      data_o
);
	initial begin
		reg_en_o = 0;
		wr_o = 0;
		addr_o = 0;
		data_o = 0;
	end
	task automatic power(input logic on);
		@(posedge clk_i);
		#2 reg_en_o = on; // host raises or drops enable
	endtask
	task automatic patch(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#2 wr_o = 1; // one byte per strobe
		addr_o = a;
		data_o = d;
		@(posedge clk_i);
		#2 wr_o = 0;
		addr_o = ~a;
		data_o = ~d;
	endtask
endmodule

// *** sim/btprc_ctrl_tb.sv ***
// Purpose: self-checking bench of the core power and reset controller
// Assumes: default reset hold of 16 cycles
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/100ps
module btprc_ctrl_tb;
	logic        clk = 0, rst = 1, io = 1, low_power_osc_input = 0, lreq = 0, pkt = 0, fm = 0;
	logic [15:0] wi  = 16'h0003;
	logic [5:0]  rda = 6'h00, wa;
	logic [7:0]  wd, rdd;
	logic        en, wr, crst, csup, rsup, oen_n, irx, rf, fmp, rom, lsel, pp;
	int          fail_count = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	btprc_host host (.clk_i(clk), .reg_en_o(en), .wr_o(wr), .addr_o(wa), .data_o(wd));
	btprc_ctrl dut (.CLK_I(clk), .RST_I(rst), .RADIO_REGULATOR_ENABLE_I(en), .IO_SUPPLY_I(io),
		.LOW_POWER_OSC_INPUT_I(low_power_osc_input), .LOWPWR_REQ_I(lreq), .WAKE_INTERVAL_I(wi), .PKT_ACTIVE_I(pkt),
		.FM_ON_I(fm), .PATCH_VALID_I(wr), .PATCH_ADDR_I(wa), .PATCH_DATA_I(wd), .PATCH_RD_ADDR_I(rda),
		.CORE_RESET_O(crst), .CORE_SUPPLY_EN_O(csup), .RF_SUPPLY_EN_O(rsup), .IO_OUT_EN_N_O(oen_n),
		.IN_RX_EN_O(irx), .RF_ON_O(rf), .FM_POWER_O(fmp), .RUN_FROM_ROM_O(rom),
		.LOWPWR_CLK_SEL_O(lsel), .PATCH_PRESENT_O(pp), .PATCH_RD_DATA_O(rdd));
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_power;
		cy(5);
		chk("core_reset", 1, crst); // enable low
		host.power(1);
		cy(10);
		chk("core_reset", 1, crst); // sync and hold
		cy(15);
		chk("core_reset", 0, crst); // released
		chk("run_rom", 1, rom); // boot
		chk("io_out_en_n", 0, oen_n); // pins driven
		$display("t_power done");
	endtask
	task automatic t_lowpwr;
		pkt = 1;
		cy(2);
		chk("rf_on", 1, rf); // packet
		lreq = 1;
		cy(1);
		lreq = 0;
		chk("lp_clk_sel", 1, lsel); // sleep
		chk("rf_on", 0, rf); // idle rf
		repeat (3) begin
			chk("lp_clk_sel", 1, lsel); // asleep
			low_power_osc_input = 1;
			cy(1);
			low_power_osc_input = 0;
			cy(2);
		end
		chk("lp_clk_sel", 0, lsel); // woke
		chk("rf_on", 1, rf); // rf back with packet
		pkt = 0;
		cy(2);
		chk("rf_on", 0, rf); // no packet
		wi = 16'h0000;
		lreq = 1;
		cy(1);
		lreq = 0;
		chk("lp_clk_sel", 1, lsel); // zero interval sleep
		low_power_osc_input = 1;
		cy(1);
		low_power_osc_input = 0;
		cy(1);
		chk("lp_clk_sel", 0, lsel); // zero acts as one tick
		$display("t_lowpwr done");
	endtask
	task automatic t_patch;
		host.patch(6'h00, 8'h5a);
		host.patch(6'h2a, 8'hc3);
		rda = 6'h2a;
		cy(2);
		chk("patch_data", 8'hc3, rdd); // stored
		chk("patch_present", 1, pp); // stored
		rda = 6'h00;
		cy(2);
		chk("patch_data", 8'h5a, rdd); // stored
		rda = 6'h3f;
		cy(2);
		chk("patch_data", 8'h00, rdd); // released bus not stored
		$display("t_patch done");
	endtask
	task automatic t_shut;
		fm = 1;
		cy(2);
		chk("fm_power", 1, fmp); // fully on
		host.power(0);
		cy(5);
		chk("core_reset", 1, crst); // defined state
		chk("core_sup", 0, csup); // off
		chk("rf_sup", 0, rsup); // off
		chk("io_out_en_n", 1, oen_n); // tristate
		chk("in_rx_en", 0, irx); // inputs off
		chk("fm_power", 0, fmp); // fully off
		host.power(1);
		cy(25);
		chk("core_reset", 0, crst); // normal power-up
		chk("patch_present", 0, pp); // nothing kept
		chk("patch_data", 8'h00, rdd); // nothing kept
		chk("fm_power", 1, fmp); // back on with request
		fm = 0;
		host.patch(6'h01, 8'h3c);
		rda = 6'h00;
		cy(2);
		chk("fm_power", 0, fmp); // fully off
		chk("patch_data", 8'h00, rdd); // old byte not revived
		rda = 6'h01;
		cy(2);
		chk("patch_data", 8'h3c, rdd); // new byte
		$display("t_shut done");
	endtask
	task automatic t_reset;
		io = 0;
		cy(2);
		chk("core_sup", 0, csup); // io supply lost
		chk("io_out_en_n", 1, oen_n); // tristate
		chk("patch_present", 0, pp); // nothing kept
		io = 1;
		cy(25);
		chk("core_reset", 0, crst); // normal power-up
		host.patch(6'h02, 8'h77);
		chk("patch_present", 1, pp); // stored
		rst = 1;
		cy(2);
		chk("core_reset", 1, crst); // defined state
		chk("rf_sup", 0, rsup); // defined state
		chk("patch_present", 0, pp); // defined state
		rst = 0;
		cy(10);
		chk("core_reset", 1, crst); // resynchronising
		cy(15);
		chk("core_reset", 0, crst); // released again
		$display("t_reset done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		#2 rst = 0;
		t_power();
		t_lowpwr();
		t_patch();
		t_shut();
		t_reset();
		end_of_test();
	end
endmodule
